// [rtl/timer0_period_timer.v]
// period timer: 8-bit period-match or 16-bit free-running counter, byte registers
// assumes all source inputs are sampled levels synchronous to core_clk_i
`timescale 1ns/1ps
`include "timer0_period_timer_map.vh"

module timer0_period_timer
(
    // clock, reset, enable
    input wire core_clk_i,
    input wire srst_i,
    input wire ce_i,
    // register port
    input wire [11:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    // clock sources, sampled levels
    input wire pin_clk_i,
    input wire instr_clk_i,
    input wire hfosc_i,
    input wire lfosc_i,
    input wire secosc_i,
    // system state and interrupt control
    input wire sleep_i,
    input wire int_enable_i,
    input wire flag_clear_i,
    // outputs
    output reg timer_output_signal_o,
    output reg timer_interrupt_flag_o,
    output reg irq_o,
    output reg wake_o
);

// ----------------------------------------
// registers
// ----------------------------------------
reg [7:0] count_low;
reg [7:0] count_high;
reg [7:0] high_latch;
reg [7:0] high_wbuf;
reg [7:0] period_buf;
reg [7:0] period_reg;
reg enable_bit;
reg wide_mode_select;
reg [3:0] postscale_select;
reg [2:0] clock_source_select;
reg unsynchronized_count_enable;
reg [3:0] prescale_select;
reg [14:0] pre_count;
reg [3:0] post_count;
reg src_prev;

// ----------------------------------------
// clock source and prescaler
// ----------------------------------------
reg src_level;
always @*
begin
    case (clock_source_select)
        `SRC_PIN: src_level = pin_clk_i;
        `SRC_PIN_INV: src_level = ~pin_clk_i;
        `SRC_INSTR: src_level = instr_clk_i;
        `SRC_HFOSC: src_level = hfosc_i;
        `SRC_LFOSC: src_level = lfosc_i;
        `SRC_SECOSC: src_level = secosc_i;
        // reserved codes give no clock
        default: src_level = 1'b0;
    endcase
end

wire src_edge = src_level & ~src_prev;

// ratio two power n, terminal count mask
function [14:0] pre_mask;
    input [3:0] code;
    begin
        pre_mask = (`PRE_ONE << code) - `PRE_ONE;
    end
endfunction

wire [14:0] mask = pre_mask(prescale_select);
wire pre_out = src_edge & ((pre_count & mask) == mask);

// sync mode: only tick on instruction clock phase; async: every prescaler output
// synchronised counting halts asleep
wire sync_ok = instr_clk_i & ~sleep_i;
wire tick = enable_bit & pre_out & (unsynchronized_count_enable | sync_ok);

// ----------------------------------------
// counting events
// ----------------------------------------
// period match on buffered copy
wire match8 = ~wide_mode_select & (count_low == period_buf);
wire roll16 = wide_mode_select & (&count_low) & (&count_high);
wire event_hit = tick & (match8 | roll16);
// flag every code plus one events
wire post_hit = event_hit & (post_count == postscale_select);

// ----------------------------------------
// register writes
// ----------------------------------------
// one decode shared by every strobe, so a moved offset changes in one place
function addr_is;
    input [11:0] addr;
    input [11:0] target;
    begin
        addr_is = (addr == target);
    end
endfunction

wire wr_low = wr_i & addr_is(addr_i, `ADDR_COUNT_LOW);
wire wr_high = wr_i & addr_is(addr_i, `ADDR_COUNT_HIGH);
wire wr_cf = wr_i & addr_is(addr_i, `ADDR_CONTROL_FIRST);
wire wr_cs = wr_i & addr_is(addr_i, `ADDR_CONTROL_SECOND);
wire rd_low = rd_i & addr_is(addr_i, `ADDR_COUNT_LOW);
wire scaler_clr = wr_low | wr_cf | wr_cs;

// ----------------------------------------
// control registers
// ----------------------------------------
always @(posedge core_clk_i)
begin
    if (srst_i)
    begin
        enable_bit <= 1'b0;
        wide_mode_select <= 1'b0;
        postscale_select <= `RESET_POST;
        clock_source_select <= `SRC_PIN;
        unsynchronized_count_enable <= 1'b0;
        prescale_select <= `RESET_POST;
    end
    else if (ce_i)
    begin
        // output bit and bit 6 are not writable
        if (wr_cf)
        begin
            enable_bit <= wdata_i[`CF_ENABLE_BIT];
            wide_mode_select <= wdata_i[`CF_WIDE_BIT];
            postscale_select <= wdata_i[`CF_POST_HI:`CF_POST_LO];
        end
        if (wr_cs)
        begin
            clock_source_select <= wdata_i[`CS_SRC_HI:`CS_SRC_LO];
            unsynchronized_count_enable <= wdata_i[`CS_ASYNC_BIT];
            prescale_select <= wdata_i[`CS_PRE_HI:`CS_PRE_LO];
        end
    end
end

// ----------------------------------------
// prescaler and postscaler
// ----------------------------------------
// a source switch can look like an edge; a following low write clears it away
always @(posedge core_clk_i)
begin
    if (srst_i)
    begin
        src_prev <= 1'b0;
        pre_count <= `RESET_PRESCALE;
        post_count <= `RESET_POST;
    end
    else if (ce_i)
    begin
        src_prev <= src_level;
        // prescaler advances on every source edge, even between ticks
        if (scaler_clr)
            pre_count <= `RESET_PRESCALE;
        else if (src_edge)
            pre_count <= pre_count + `PRE_ONE;
        if (scaler_clr)
            post_count <= `RESET_POST;
        else if (post_hit)
            post_count <= `RESET_POST;
        else if (event_hit)
            post_count <= post_count + `POST_ONE;
    end
end

// ----------------------------------------
// counter and byte buffers
// ----------------------------------------
always @(posedge core_clk_i)
begin
    if (srst_i)
    begin
        count_low <= `RESET_BYTE;
        count_high <= `RESET_BYTE;
        high_latch <= `RESET_BYTE;
        high_wbuf <= `RESET_BYTE;
        period_buf <= `RESET_BYTE;
        period_reg <= `RESET_BYTE;
    end
    else if (ce_i)
    begin
        if (wr_high)
        begin
            high_wbuf <= wdata_i;
            period_reg <= wdata_i;
        end
        // software write wins over a tick in the same cycle
        if (wr_low)
        begin
            count_low <= wdata_i;
            if (wide_mode_select)
                count_high <= high_wbuf;
        end
        else if (tick)
        begin
            if (match8)
            begin
                count_low <= `RESET_BYTE;
                period_buf <= period_reg;
            end
            else
            begin
                count_low <= count_low + `COUNT_ONE;
                if (wide_mode_select & (&count_low))
                    count_high <= count_high + `COUNT_ONE;
            end
        end
        // buffer follows the register while stopped in 8-bit mode, so a new period starts clean
        if (~enable_bit & ~wide_mode_select)
            period_buf <= period_reg;
        if (rd_low)
            high_latch <= count_high;
    end
end

// ----------------------------------------
// output, flag and requests
// ----------------------------------------
// requests lag the flag by one cycle; the set event is folded in to hide it
always @(posedge core_clk_i)
begin
    if (srst_i)
    begin
        timer_output_signal_o <= 1'b0;
        timer_interrupt_flag_o <= 1'b0;
        irq_o <= 1'b0;
        wake_o <= 1'b0;
    end
    else if (ce_i)
    begin
        if (post_hit)
            timer_output_signal_o <= ~timer_output_signal_o;
        if (post_hit)
            timer_interrupt_flag_o <= 1'b1;
        else if (flag_clear_i)
            timer_interrupt_flag_o <= 1'b0;
        irq_o <= (timer_interrupt_flag_o | post_hit) & int_enable_i;
        wake_o <= (timer_interrupt_flag_o | post_hit) & int_enable_i & sleep_i;
    end
end

// ----------------------------------------
// read data
// ----------------------------------------
// data stand one cycle only, zero otherwise, so a bus can or the ports together
always @(posedge core_clk_i)
begin
    if (srst_i)
    begin
        rdata_o <= `RESET_BYTE;
    end
    else if (ce_i)
    begin
        if (rd_i)
        begin
            case (addr_i)
                `ADDR_COUNT_LOW: rdata_o <= count_low;
                `ADDR_COUNT_HIGH: rdata_o <= wide_mode_select ? high_latch : period_reg;
                `ADDR_CONTROL_FIRST: rdata_o <= {enable_bit, 1'b0, timer_output_signal_o,
                    wide_mode_select, postscale_select};
                `ADDR_CONTROL_SECOND: rdata_o <= {clock_source_select,
                    unsynchronized_count_enable, prescale_select};
                default: rdata_o <= `RESET_BYTE;
            endcase
        end
        else
        begin
            rdata_o <= `RESET_BYTE;
        end
    end
end

endmodule

// [rtl/timer0_period_timer_map.vh]
// register offsets, field positions, reset values and source codes of the period timer
// included by the timer module by bare name
`ifndef TIMER0_PERIOD_TIMER_MAP_VH
`define TIMER0_PERIOD_TIMER_MAP_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_COUNT_LOW 12'hfd3
`define ADDR_COUNT_HIGH 12'hfd4
`define ADDR_CONTROL_FIRST 12'hfd5
`define ADDR_CONTROL_SECOND 12'hfd6

// ----------------------------------------
// field positions
// ----------------------------------------
`define CF_ENABLE_BIT 7
`define CF_OUT_BIT 5
`define CF_WIDE_BIT 4
`define CF_POST_HI 3
`define CF_POST_LO 0
`define CS_SRC_HI 7
`define CS_SRC_LO 5
`define CS_ASYNC_BIT 4
`define CS_PRE_HI 3
`define CS_PRE_LO 0

// ----------------------------------------
// reset values and constants
// ----------------------------------------
`define RESET_BYTE 8'h00
`define RESET_PRESCALE 15'h0000
`define RESET_POST 4'h0
`define COUNT_ONE 8'h01
`define PRE_ONE 15'h0001
`define POST_ONE 4'h1
`define CF_WRITE_MASK 8'h9f

// ----------------------------------------
// clock source codes
// ----------------------------------------
`define SRC_PIN 3'h0
`define SRC_PIN_INV 3'h1
`define SRC_INSTR 3'h2
`define SRC_HFOSC 3'h3
`define SRC_LFOSC 3'h4
`define SRC_SECOSC 3'h5

`endif

// [test/timer0_period_timer_bench.sv]
// bench: register-level scenarios for the period timer
// assumes the sources are plain levels driven from this bench
`timescale 1ns/1ps
module timer0_period_timer_bench;
    localparam [11:0] a_lo = 12'hfd3;
    localparam [11:0] a_hi = 12'hfd4;
    localparam [11:0] a_c0 = 12'hfd5;
    localparam [11:0] a_c1 = 12'hfd6;
    reg core_clk_i = 1'b0;
    reg srst_i = 1'b1;
    reg [11:0] addr_i = 12'h000;
    reg [7:0] wdata_i = 8'h00;
    reg wr_i = 1'b0;
    reg rd_i = 1'b0;
    reg [4:0] src = 5'h00;
    reg sleep_i = 1'b0;
    reg int_enable_i = 1'b0;
    reg flag_clear_i = 1'b0;
    wire [7:0] rdata_o;
    wire out_s;
    wire flag_s;
    wire irq_s;
    wire wake_s;
    integer error_cnt = 0;
    integer n_checks = 0;
    integer cyc = 0;
    integer c;
    timer0_period_timer dut_u (.core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(1'b1),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .pin_clk_i(src[0]), .instr_clk_i(src[1]), .hfosc_i(src[2]), .lfosc_i(src[3]),
        .secosc_i(src[4]), .sleep_i(sleep_i), .int_enable_i(int_enable_i),
        .flag_clear_i(flag_clear_i), .timer_output_signal_o(out_s),
        .timer_interrupt_flag_o(flag_s), .irq_o(irq_s), .wake_o(wake_s));
    initial forever #4 core_clk_i = ~core_clk_i;
    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task conclude;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge core_clk_i)
    begin
        cyc <= cyc + 1;
        // the sweeps need about 33000 cycles
        if (cyc == 60000)
        begin
            error_cnt = error_cnt + 1;
            conclude;
        end
    end
    task chk(input [7:0] got, input [7:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task st(input [1:0] e);
        chk({6'h00, out_s, flag_s}, {6'h00, e});
    endtask
    task wr(input [11:0] a, input [7:0] d);
        @(posedge core_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
    endtask
    task rd(input [11:0] a, input [7:0] e);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, e);
    endtask
    // one rising edge per two cycles, then time for the count to land
    task pulse(input integer i, input integer n);
        repeat (n)
        begin
            @(posedge core_clk_i);
            src[i] <= ~src[i];
            @(posedge core_clk_i);
            src[i] <= ~src[i];
        end
        repeat (2) @(posedge core_clk_i);
    endtask
    task clr;
        @(posedge core_clk_i);
        flag_clear_i <= 1'b1;
        @(posedge core_clk_i);
        flag_clear_i <= 1'b0;
        @(posedge core_clk_i);
    endtask
    // period 0: every tick is an event, toggle after 2^p * (q+1) edges
    task scale(input [3:0] p, input [3:0] q);
        reg o;
        wr(a_c1, {4'h1, p});
        wr(a_c0, {4'h8, q});
        wr(a_lo, 8'h00);
        o = out_s;
        pulse(0, (2 ** p) * (q + 1) - 1);
        chk({7'h00, out_s}, {7'h00, o});
        pulse(0, 1);
        chk({7'h00, out_s}, {7'h00, ~o});
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_reset;
        rd(a_lo, 8'h00);
        rd(a_hi, 8'h00);
        rd(a_c0, 8'h00);
        rd(a_c1, 8'h00);
        wr(a_c0, 8'hff);
        rd(a_c0, 8'h9f);
        wr(12'hfd7, 8'h55);
        rd(12'hfd7, 8'h00);
        wr(a_c0, 8'h00);
        wr(a_c1, 8'h10);
        pulse(0, 2);
        rd(a_lo, 8'h00);
        $display("reset test done");
    endtask
    task t_period;
        wr(a_hi, 8'h03);
        wr(a_c0, 8'h80);
        pulse(0, 3);
        rd(a_lo, 8'h03);
        st(2'b00);
        pulse(0, 1);
        rd(a_lo, 8'h00);
        st(2'b11);
        wr(a_hi, 8'h01);
        pulse(0, 2);
        rd(a_lo, 8'h02);
        clr;
        st(2'b10);
        $display("period test done");
    endtask
    task t_scale;
        wr(a_c0, 8'h00);
        wr(a_hi, 8'h00);
        for (c = 0; c < 16; c = c + 1)
            scale(4'h0, c[3:0]);
        for (c = 0; c < 14; c = c + 1)
            scale(c[3:0], 4'h0);
        scale(4'h1, 4'h2);
        pulse(0, 1);
        wr(a_lo, 8'h00);
        pulse(0, 5);
        st(2'b01);
        pulse(0, 1);
        st(2'b11);
        clr;
        $display("scale test done");
    endtask
    task t_src;
        wr(a_c0, 8'h00);
        wr(a_hi, 8'hff);
        wr(a_c0, 8'h80);
        for (c = 0; c < 8; c = c + 1)
        begin
            wr(a_c1, {c[2:0], 5'h10});
            wr(a_lo, 8'h00);
            pulse((c > 1 && c < 6) ? c - 1 : 0, 1);
            rd(a_lo, (c < 6) ? 8'h01 : 8'h00);
        end
        $display("source test done");
    endtask
    task t_wide;
        reg o;
        wr(a_c0, 8'h90);
        wr(a_c1, 8'h10);
        wr(a_hi, 8'hff);
        wr(a_lo, 8'hfe);
        rd(a_lo, 8'hfe);
        o = out_s;
        pulse(0, 2);
        rd(a_hi, 8'hff);
        chk({7'h00, out_s}, {7'h00, ~o});
        rd(a_lo, 8'h00);
        rd(a_hi, 8'h00);
        wr(a_hi, 8'h5a);
        pulse(0, 1);
        rd(a_lo, 8'h01);
        rd(a_hi, 8'h00);
        wr(a_c0, 8'h10);
        wr(a_lo, 8'h10);
        rd(a_lo, 8'h10);
        rd(a_hi, 8'h5a);
        clr;
        $display("wide test done");
    endtask
    task t_sleep;
        wr(a_c0, 8'h00);
        wr(a_hi, 8'hff);
        wr(a_c0, 8'h80);
        wr(a_c1, 8'h00);
        wr(a_lo, 8'h00);
        pulse(0, 1);
        rd(a_lo, 8'h00);
        @(posedge core_clk_i);
        src[1] <= 1'b1;
        pulse(0, 1);
        rd(a_lo, 8'h01);
        @(posedge core_clk_i);
        sleep_i <= 1'b1;
        pulse(0, 1);
        rd(a_lo, 8'h01);
        wr(a_c0, 8'h00);
        wr(a_hi, 8'h00);
        wr(a_c1, 8'h10);
        int_enable_i <= 1'b1;
        wr(a_c0, 8'h80);
        wr(a_lo, 8'h00);
        pulse(0, 1);
        chk({6'h00, irq_s, wake_s}, 8'h03);
        sleep_i <= 1'b0;
        int_enable_i <= 1'b0;
        clr;
        $display("sleep test done");
    endtask
    initial
    begin
        repeat (5) @(posedge core_clk_i);
        srst_i <= 1'b0;
        t_reset;
        t_period;
        t_scale;
        t_src;
        t_wide;
        t_sleep;
        conclude;
    end
endmodule
bind timer0_period_timer timer0_period_timer_checker chk_u (.core_clk_i(core_clk_i),
    .srst_i(srst_i), .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sleep_i(sleep_i),
    .int_enable_i(int_enable_i), .flag_clear_i(flag_clear_i),
    .timer_output_signal_o(timer_output_signal_o),
    .timer_interrupt_flag_o(timer_interrupt_flag_o), .irq_o(irq_o), .wake_o(wake_o));

// [test/timer0_period_timer_checker.sv]
// checker: port-level timing relations of the period timer
// assumes ce_i is held high, so every edge is a live edge
`timescale 1ns/1ps
module timer0_period_timer_checker
(
    // clock and reset
    input wire core_clk_i,
    input wire srst_i,
    // register port
    input wire [11:0] addr_i,
    input wire rd_i,
    input wire [7:0] rdata_o,
    // system state
    input wire sleep_i,
    input wire int_enable_i,
    input wire flag_clear_i,
    // outputs
    input wire timer_output_signal_o,
    input wire timer_interrupt_flag_o,
    input wire irq_o,
    input wire wake_o
);
    // ----------------------------------------
    // sequences and properties
    // ----------------------------------------
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    sequence ctl_read;
        rd_i && addr_i == 12'hfd5;
    endsequence
    // a clear that meets no setting event in the same edge
    sequence clear_quiet;
        flag_clear_i ##1 !$changed(timer_output_signal_o);
    endsequence
    out_readback_a: assert property (
        ctl_read |=> rdata_o[6:5] == {1'b0, $past(timer_output_signal_o)})
        else $error("control read shows wrong output state");
    flag_on_toggle_a: assert property (
        $changed(timer_output_signal_o) |-> timer_interrupt_flag_o)
        else $error("output toggled without flag");
    flag_hold_a: assert property (
        timer_interrupt_flag_o && !flag_clear_i |=> timer_interrupt_flag_o)
        else $error("flag dropped without clear");
    flag_clear_a: assert property (clear_quiet |-> !timer_interrupt_flag_o)
        else $error("flag survived clear");
    irq_enabled_a: assert property (
        timer_interrupt_flag_o && int_enable_i |=> irq_o)
        else $error("enabled flag gave no request");
    irq_gated_a: assert property (irq_o |-> $past(int_enable_i))
        else $error("request while disabled");
    wake_sleep_a: assert property (wake_o == (irq_o && $past(sleep_i)))
        else $error("wake does not follow request in sleep");
    rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data outside read slot");
endmodule
